// ==== verilog/sbra_pkg.sv ====
// sbra_pkg: constants and types shared by the system bus release arbiter ends
// assumes: both ends, the clock source and the testbench import it whole
package sbra_pkg;

	// ==========================================================
	// arbiter states, one-hot
	typedef enum logic [2:0] {
		SBRA_IDLE = 3'h1,
		SBRA_REQ = 3'h2,
		SBRA_OWN = 3'h4
	} sbra_state_type;

	// ==========================================================
	// release modes
	typedef enum logic [1:0] {
		SBRA_MODE1 = 2'h1,
		SBRA_MODE2 = 2'h2,
		SBRA_MODE3 = 2'h3
	} sbra_mode_type;

	// ==========================================================
	// counts and reset values
	localparam logic [3:0] SBRA_XFER_CYC = 4'h4; // link cycles per transfer
	localparam logic [1:0] SBRA_STRAP_WAIT = 2'h3; // link edges before strap capture
	localparam logic [3:0] SBRA_CLK_HALF = 4'h2; // sys cycles per bus clock half
	localparam logic [2:0] SBRA_SYNC_RST = 3'h0;
	localparam logic [3:0] SBRA_SYNC4_RST = 4'h0;

endpackage

// ==== verilog/sbra_bus_if.sv ====
// sbra_bus_if: the shared system bus lines between the two arbiter ends
// assumes: the bench supplies a free bus clock used when no end drives one
`timescale 1ns/1ps
`default_nettype none
interface sbra_bus_if (
	input wire logic bench_bclk
);
	// ==========================================================
	// clock drivers, one set per end
	logic dev_bclk_o, dev_bclk_oe, dev_cclk_o, dev_cclk_oe;
	logic far_bclk_o, far_bclk_oe, far_cclk_o, far_cclk_oe;
	// open-drain lines, per end, lock from the device end only
	logic dev_busy_o, dev_busy_oe, far_busy_o, far_busy_oe;
	logic dev_cbrq_o, dev_cbrq_oe, far_cbrq_o, far_cbrq_oe;
	logic dev_lock_o, dev_lock_oe;
	// point-to-point lines
	logic bprn_n, bpro_n, request_lock_input;
	// resolved wire levels
	logic bclk, cclk, busy_n, cbrq_n, lock_n;

	// resolve clocks: the device end wins, then the far end, else the bench clock (inverted for cclk)
	assign bclk = dev_bclk_oe ? dev_bclk_o : (far_bclk_oe ? far_bclk_o : bench_bclk);
	assign cclk = dev_cclk_oe ? dev_cclk_o : (far_cclk_oe ? far_cclk_o : ~bench_bclk);
	// open-drain: low when any end enables its driver
	assign busy_n = !((dev_busy_oe && !dev_busy_o) || (far_busy_oe && !far_busy_o));
	assign cbrq_n = !((dev_cbrq_oe && !dev_cbrq_o) || (far_cbrq_oe && !far_cbrq_o));
	assign lock_n = !(dev_lock_oe && !dev_lock_o);

	modport dev (
		output dev_bclk_o, dev_bclk_oe, dev_cclk_o, dev_cclk_oe,
		output dev_busy_o, dev_busy_oe, dev_cbrq_o, dev_cbrq_oe, dev_lock_o, dev_lock_oe,
		output bpro_n,
		input bprn_n, request_lock_input, bclk, cclk, busy_n, cbrq_n, lock_n
	);
	modport far (
		output far_bclk_o, far_bclk_oe, far_cclk_o, far_cclk_oe,
		output far_busy_o, far_busy_oe, far_cbrq_o, far_cbrq_oe,
		output bprn_n, request_lock_input,
		input bpro_n, bclk, cclk, busy_n, cbrq_n, lock_n
	);
endinterface
`default_nettype wire

// ==== verilog/sbra_clk_src.sv ====
// sbra_clk_src: divides the system clock into bus clock and constant clock
// assumes: drive_en is a level from the system clock domain
`timescale 1ns/1ps
`default_nettype none
module sbra_clk_src
	import sbra_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// control
	input wire logic drive_en,
	// bus clock pins
	output logic bclk_o,
	output logic bclk_oe,
	output logic cclk_o,
	output logic cclk_oe
);
	// ==========================================================
	// divider
	logic [3:0] cnt_q;
	logic phase_q;
	logic en_q;

	// half-period counter and bus clock phase
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= SBRA_SYNC4_RST;
			phase_q <= 1'b0;
		end else if (cnt_q == SBRA_CLK_HALF - 4'h1) begin
			cnt_q <= SBRA_SYNC4_RST;
			phase_q <= ~phase_q;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end

	// driver enable, registered
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= 1'b0;
		end else begin
			en_q <= drive_en;
		end
	end

	assign bclk_o = phase_q;
	assign cclk_o = ~phase_q;
	assign bclk_oe = en_q;
	assign cclk_oe = en_q;
endmodule
`default_nettype wire

// ==== verilog/sbra_device.sv ====
// sbra_device: system bus release arbiter of the board, with local cycle port
// assumes: the bus clock on the interface clocks the arbiter; local side on clk_sys
`timescale 1ns/1ps
`default_nettype none
module sbra_device
	import sbra_pkg::*;
(
	// clocks and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// bus side
	sbra_bus_if.dev bus,
	// local side
	input wire logic xfer_req,
	output logic xfer_ack,
	output logic xfer_busy,
	input wire logic bus_override_n,
	input wire logic clk_drive_en,
	// status
	output logic owner,
	output sbra_mode_type mode
);
	// ==========================================================
	// bus clock source
	sbra_clk_src u_clk (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.drive_en(clk_drive_en),
		.bclk_o(bus.dev_bclk_o),
		.bclk_oe(bus.dev_bclk_oe),
		.cclk_o(bus.dev_cclk_o),
		.cclk_oe(bus.dev_cclk_oe)
	);

	logic lclk;
	assign lclk = bus.bclk;

	// ==========================================================
	// local side: request toggle out, acknowledge toggle back
	logic req_tgl_q;
	logic pend_sys_q;
	logic [2:0] ack_sync_q;
	logic ack_tgl_q;

	// request toggle, one per accepted local cycle
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			req_tgl_q <= 1'b0;
		end else if (xfer_req && !pend_sys_q) begin
			req_tgl_q <= ~req_tgl_q;
		end
	end

	// acknowledge synchroniser and edge detect
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_sync_q <= SBRA_SYNC_RST;
		end else begin
			ack_sync_q <= {ack_sync_q[1:0], ack_tgl_q};
		end
	end

	assign xfer_ack = ack_sync_q[2] ^ ack_sync_q[1];

	// pending flag, set by a request, cleared by its acknowledge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pend_sys_q <= 1'b0;
		end else if (xfer_req && !pend_sys_q) begin
			pend_sys_q <= 1'b1;
		end else if (xfer_ack) begin
			pend_sys_q <= 1'b0;
		end
	end

	assign xfer_busy = pend_sys_q;

	// ==========================================================
	// link side synchronisers
	// bit order: request toggle, override, strap, priority in, common req, busy, lock
	localparam int NSYNC = 7;
	logic [NSYNC-1:0] raw, s1_q, s2_q;
	logic req_s3_q;
	assign raw = {req_tgl_q, bus_override_n, bus.request_lock_input,
		bus.bprn_n, bus.cbrq_n, bus.busy_n, bus.lock_n};

	// two flip-flops on every input from outside the link domain
	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			req_s3_q <= 1'b0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			req_s3_q <= s2_q[6];
		end
	end

	logic req_edge, ovr_n_s, strap_s, bprn_n_s, cbrq_n_s, busy_n_s;
	assign req_edge = s2_q[6] ^ req_s3_q;
	assign ovr_n_s = s2_q[5];
	assign strap_s = s2_q[4];
	assign bprn_n_s = s2_q[3];
	assign cbrq_n_s = s2_q[2];
	assign busy_n_s = s2_q[1];

	// ==========================================================
	// strap capture after reset release
	logic [1:0] strap_cnt_q;
	logic strap_hi_q;

	// waits for the synchroniser to fill, then keeps the strap level
	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			strap_cnt_q <= 2'h0;
			strap_hi_q <= 1'b0;
		end else if (strap_cnt_q != SBRA_STRAP_WAIT) begin
			strap_cnt_q <= strap_cnt_q + 2'h1;
			strap_hi_q <= strap_s;
		end
	end

	// mode: strap low means always release; else live pin picks 2 or 3
	always_comb begin
		if (!strap_hi_q) begin
			mode = SBRA_MODE1;
		end else if (strap_s) begin
			mode = SBRA_MODE2;
		end else begin
			mode = SBRA_MODE3;
		end
	end

	// ==========================================================
	// arbiter state machine
	sbra_state_type state_q;
	logic pend_q;
	logic [3:0] xcnt_q;
	logic locked;
	logic release_now;
	logic take_bus;

	assign locked = !ovr_n_s;
	assign take_bus = !bprn_n_s && busy_n_s;

	// release decision once no transfer is running
	always_comb begin
		case (mode)
			SBRA_MODE1: release_now = 1'b1;
			SBRA_MODE2: release_now = bprn_n_s || !cbrq_n_s;
			SBRA_MODE3: release_now = bprn_n_s;
			default: release_now = 1'b1;
		endcase
		if (locked || pend_q || xcnt_q != 4'h0) begin
			release_now = 1'b0;
		end
	end

	// pending transfer in the link domain
	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= 1'b0;
		end else if (req_edge) begin
			pend_q <= 1'b1;
		end else if (state_q == SBRA_OWN && pend_q && xcnt_q == 4'h0) begin
			pend_q <= 1'b0;
		end
	end

	// transfer counter runs while a transfer is on the bus
	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			xcnt_q <= 4'h0;
		end else if (state_q == SBRA_OWN && pend_q && xcnt_q == 4'h0) begin
			xcnt_q <= SBRA_XFER_CYC;
		end else if (xcnt_q != 4'h0) begin
			xcnt_q <= xcnt_q - 4'h1;
		end
	end

	// acknowledge toggles as the last transfer cycle ends
	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_tgl_q <= 1'b0;
		end else if (xcnt_q == 4'h1) begin
			ack_tgl_q <= ~ack_tgl_q;
		end
	end

	// ownership state
	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SBRA_IDLE;
		end else begin
			case (state_q)
				SBRA_IDLE: begin
					if (pend_q) begin
						state_q <= SBRA_REQ;
					end
				end
				SBRA_REQ: begin
					if (take_bus) begin
						state_q <= SBRA_OWN;
					end
				end
				SBRA_OWN: begin
					if (release_now) begin
						state_q <= SBRA_IDLE;
					end
				end
				default: state_q <= SBRA_IDLE;
			endcase
		end
	end

	// ==========================================================
	// bus drivers
	logic bpro_q;

	// priority out: passed on only while idle and not wanting the bus
	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			bpro_q <= 1'b1;
		end else begin
			bpro_q <= !(state_q == SBRA_IDLE && !pend_q && !bprn_n_s);
		end
	end

	assign bus.bpro_n = bpro_q;
	assign bus.dev_busy_o = 1'b0;
	assign bus.dev_busy_oe = (state_q == SBRA_OWN);
	assign bus.dev_cbrq_o = 1'b0;
	assign bus.dev_cbrq_oe = (state_q == SBRA_REQ);
	assign bus.dev_lock_o = 1'b0;
	assign bus.dev_lock_oe = (state_q == SBRA_OWN) && locked;
	assign owner = (state_q == SBRA_OWN);
endmodule
`default_nettype wire

// ==== verilog/sbra_far.sv ====
// sbra_far: another master's arbiter of higher priority on the same bus
// assumes: want may come from any clock and is synchronised; clk_sys feeds the clock source
`timescale 1ns/1ps
`default_nettype none
module sbra_far
	import sbra_pkg::*;
(
	// clocks and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// bus side
	sbra_bus_if.far bus,
	// user side
	input wire logic want,
	input wire logic strap_level,
	input wire logic clk_drive_en,
	output logic granted,
	output logic prio_passed
);
	// ==========================================================
	// optional bus clock source
	sbra_clk_src u_clk (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.drive_en(clk_drive_en),
		.bclk_o(bus.far_bclk_o),
		.bclk_oe(bus.far_bclk_oe),
		.cclk_o(bus.far_cclk_o),
		.cclk_oe(bus.far_cclk_oe)
	);

	logic lclk;
	assign lclk = bus.bclk;

	// ==========================================================
	// synchronisers: priority in from device, busy, lock
	logic [2:0] s1_q, s2_q;
	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= SBRA_SYNC_RST;
			s2_q <= SBRA_SYNC_RST;
		end else begin
			s1_q <= {bus.bpro_n, bus.busy_n, bus.lock_n};
			s2_q <= s1_q;
		end
	end

	// ==========================================================
	// user request, two flip-flops before the state machine reads it
	logic want_s1_q, want_s2_q;
	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			want_s1_q <= 1'b0;
			want_s2_q <= 1'b0;
		end else begin
			want_s1_q <= want;
			want_s2_q <= want_s1_q;
		end
	end

	// ==========================================================
	// ownership state
	sbra_state_type state_q;
	always_ff @(posedge lclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SBRA_IDLE;
		end else begin
			case (state_q)
				SBRA_IDLE: begin
					if (want_s2_q) begin
						state_q <= SBRA_REQ;
					end
				end
				SBRA_REQ: begin
					if (!want_s2_q) begin
						state_q <= SBRA_IDLE;
					end else if (s2_q[1] && s2_q[0]) begin
						state_q <= SBRA_OWN;
					end
				end
				SBRA_OWN: begin
					if (!want_s2_q) begin
						state_q <= SBRA_IDLE;
					end
				end
				default: state_q <= SBRA_IDLE;
			endcase
		end
	end

	// ==========================================================
	// bus drivers
	assign bus.bprn_n = (state_q != SBRA_IDLE);
	assign bus.request_lock_input = strap_level;
	assign bus.far_busy_o = 1'b0;
	assign bus.far_busy_oe = (state_q == SBRA_OWN);
	assign bus.far_cbrq_o = 1'b0;
	assign bus.far_cbrq_oe = (state_q == SBRA_REQ);
	assign granted = (state_q == SBRA_OWN);
	assign prio_passed = !s2_q[2];
endmodule
`default_nettype wire

// ==== verification/sbra_monitor.sv ====
// sbra_monitor: assertions on the shared bus lines of both arbiter ends
// assumes: instantiated beside the bus interface, fed its signals
`timescale 1ns/1ps
`default_nettype none
module sbra_monitor (
	// clocks and reset
	input wire logic clk_sys,
	input wire logic bclk,
	input wire logic rst_n,
	// clock drivers
	input wire logic dev_bclk_o,
	input wire logic dev_bclk_oe,
	input wire logic dev_cclk_o,
	input wire logic dev_cclk_oe,
	input wire logic far_bclk_oe,
	// arbitration lines
	input wire logic dev_busy_oe,
	input wire logic far_busy_oe,
	input wire logic dev_cbrq_o,
	input wire logic dev_cbrq_oe,
	input wire logic busy_n,
	input wire logic lock_n,
	input wire logic bpro_n
);
	// ==========================================================
	// clock drivers
	one_bclk_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!(dev_bclk_oe && far_bclk_oe)) else $error("two bus clock drivers");
	pair_oe_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		dev_bclk_oe == dev_cclk_oe) else $error("clock enables differ");
	anti_cclk_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		dev_cclk_oe |-> dev_cclk_o != dev_bclk_o) else $error("cclk not antiphase");
	// ==========================================================
	// arbitration
	lock_own_a: assert property (@(posedge bclk) disable iff (!rst_n)
		!lock_n |-> dev_busy_oe) else $error("lock without ownership");
	far_lock_a: assert property (@(posedge bclk) disable iff (!rst_n)
		!lock_n |-> !far_busy_oe) else $error("far end busy under lock");
	one_owner_a: assert property (@(posedge bclk) disable iff (!rst_n)
		!(dev_busy_oe && far_busy_oe)) else $error("two bus owners");
	far_take_a: assert property (@(posedge bclk) disable iff (!rst_n)
		$rose(far_busy_oe) |-> $past(busy_n) && $past(lock_n)) else $error("far took held bus");
	cbrq_req_a: assert property (@(posedge bclk) disable iff (!rst_n)
		dev_cbrq_oe |-> !dev_cbrq_o && !dev_busy_oe) else $error("bad common request");
	take_req_a: assert property (@(posedge bclk) disable iff (!rst_n)
		$rose(dev_busy_oe) |-> $past(dev_cbrq_oe)) else $error("took bus unrequested");
	bpro_idle_a: assert property (@(posedge bclk) disable iff (!rst_n)
		!bpro_n |-> $past(!dev_busy_oe && !dev_cbrq_oe)) else $error("priority out when busy");
endmodule
`default_nettype wire

// ==== verification/test_system_bus_release_arbiter.sv ====
// test_system_bus_release_arbiter: device end facing far end on one bus
// assumes: bench bus clock of 64 ns, system clock of 100 ns
`timescale 1ns/1ps
`default_nettype none
module test_system_bus_release_arbiter
	import sbra_pkg::*;
;
	logic clk_sys = 1'b0;
	logic bench_bclk = 1'b0;
	logic rst_n = 1'b0;
	logic xfer_req = 1'b0;
	logic bus_override_n = 1'b1;
	logic dev_clk_en = 1'b0;
	logic far_clk_en = 1'b0;
	logic want = 1'b0;
	logic strap_level = 1'b0;
	logic xfer_ack, xfer_busy, owner, granted, prio_passed;
	sbra_mode_type mode;
	sbra_mode_type m_exp = SBRA_MODE1;
	logic [2:0] notes[$];
	int n_errors = 0;
	int check_count = 0;

	// system clock and free bench bus clock
	always #50 clk_sys = ~clk_sys;
	always #32 bench_bclk = ~bench_bclk;

	// ==========================================================
	// both ends and the monitor
	sbra_bus_if sbra_bus_if_i (.bench_bclk(bench_bclk));
	sbra_device sbra_device_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(sbra_bus_if_i.dev),
		.xfer_req(xfer_req), .xfer_ack(xfer_ack), .xfer_busy(xfer_busy),
		.bus_override_n(bus_override_n), .clk_drive_en(dev_clk_en), .owner(owner), .mode(mode));
	sbra_far sbra_far_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(sbra_bus_if_i.far), .want(want),
		.strap_level(strap_level), .clk_drive_en(far_clk_en), .granted(granted),
		.prio_passed(prio_passed));
	sbra_monitor sbra_monitor_i (.clk_sys(clk_sys), .bclk(sbra_bus_if_i.bclk), .rst_n(rst_n),
		.dev_bclk_o(sbra_bus_if_i.dev_bclk_o), .dev_bclk_oe(sbra_bus_if_i.dev_bclk_oe),
		.dev_cclk_o(sbra_bus_if_i.dev_cclk_o), .dev_cclk_oe(sbra_bus_if_i.dev_cclk_oe),
		.far_bclk_oe(sbra_bus_if_i.far_bclk_oe), .dev_busy_oe(sbra_bus_if_i.dev_busy_oe),
		.far_busy_oe(sbra_bus_if_i.far_busy_oe), .dev_cbrq_o(sbra_bus_if_i.dev_cbrq_o),
		.dev_cbrq_oe(sbra_bus_if_i.dev_cbrq_oe), .busy_n(sbra_bus_if_i.busy_n),
		.lock_n(sbra_bus_if_i.lock_n), .bpro_n(sbra_bus_if_i.bpro_n));

	// ==========================================================
	// compare, verdict, bounded waits
	task automatic check(input logic [2:0] seen, input logic [2:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH at %0t: saw %b expected %b", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		if (n_errors == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic wait_idle;
		int i;
		for (i = 0; i < 400 && xfer_busy !== 1'b0; i++) @(negedge clk_sys);
		if (xfer_busy !== 1'b0) begin
			check({2'h0, xfer_busy}, 3'h0);
			test_done;
		end
	endtask
	// request held over a second edge, which must be ignored while busy
	task automatic xfer_go(input logic exp_owner);
		notes.push_back({m_exp, exp_owner});
		xfer_req = 1'b1;
		repeat (2) @(negedge clk_sys);
		xfer_req = 1'b0;
	endtask
	task automatic do_reset(input logic strap, input sbra_mode_type m);
		rst_n = 1'b0;
		strap_level = strap;
		m_exp = m;
		repeat (20) @(negedge clk_sys);
		rst_n = 1'b1;
		repeat (10) @(negedge clk_sys);
		check({1'b0, mode}, {1'b0, m});
	endtask

	// each finished transfer against its oldest note
	always @(negedge clk_sys) begin
		if (xfer_ack === 1'b1) begin
			if (notes.size() == 0) check(3'h7, 3'h0);
			else check({mode, owner}, notes.pop_front());
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		int k;
		k = $urandom(18);
		// always release, back to back
		do_reset(1'b0, SBRA_MODE1);
		xfer_go(1'b0);
		wait_idle;
		xfer_go(1'b0);
		wait_idle;
		repeat (10) @(negedge clk_sys);
		check({1'b0, prio_passed, sbra_bus_if_i.bpro_n}, 3'h2);
		// far end holds the bus, our request waits
		want = 1'b1;
		repeat (20) @(negedge clk_sys);
		check({granted, 2'h0}, 3'h4);
		xfer_go(1'b0);
		repeat (30) @(negedge clk_sys);
		check({owner, sbra_bus_if_i.cbrq_n, 1'b0}, 3'h0);
		want = 1'b0;
		wait_idle;
		// second reset: retain mode, random gaps
		do_reset(1'b1, SBRA_MODE2);
		for (k = 0; k < 4; k++) begin
			repeat ($urandom_range(6, 1)) @(negedge clk_sys);
			xfer_go(1'b1);
			wait_idle;
		end
		check({owner, sbra_bus_if_i.bpro_n, prio_passed}, 3'h6);
		want = 1'b1;
		repeat (30) @(negedge clk_sys);
		check({owner, granted, 1'b0}, 3'h2);
		want = 1'b0;
		// live switch to higher-only release
		strap_level = 1'b0;
		m_exp = SBRA_MODE3;
		repeat (5) @(negedge clk_sys);
		xfer_go(1'b1);
		wait_idle;
		// override lock holds off the far end
		bus_override_n = 1'b0;
		want = 1'b1;
		repeat (40) @(negedge clk_sys);
		check({owner, granted, sbra_bus_if_i.lock_n}, 3'h4);
		bus_override_n = 1'b1;
		repeat (40) @(negedge clk_sys);
		check({owner, granted, sbra_bus_if_i.lock_n}, 3'h3);
		want = 1'b0;
		strap_level = 1'b1;
		m_exp = SBRA_MODE2;
		repeat (5) @(negedge clk_sys);
		xfer_go(1'b1);
		wait_idle;
		// bus clocks from the far end, then from the device end
		check({sbra_bus_if_i.dev_bclk_oe, sbra_bus_if_i.dev_cclk_oe, 1'b0}, 3'h0);
		far_clk_en = 1'b1;
		repeat (4) @(negedge clk_sys);
		check({sbra_bus_if_i.far_bclk_oe, sbra_bus_if_i.dev_bclk_oe,
			sbra_bus_if_i.cclk ^ sbra_bus_if_i.bclk}, 3'h5);
		far_clk_en = 1'b0;
		repeat (4) @(negedge clk_sys);
		dev_clk_en = 1'b1;
		repeat (4) @(negedge clk_sys);
		for (k = 0; k < 8; k++) begin
			@(negedge clk_sys);
			check({1'b0, sbra_bus_if_i.dev_bclk_oe, sbra_bus_if_i.cclk ^ sbra_bus_if_i.bclk},
				3'h3);
		end
		// a transfer still completes on the device's own bus clock
		xfer_go(1'b1);
		wait_idle;
		test_done;
	end
endmodule
`default_nettype wire
